// File: design/ieb_lane_if.sv
// Interface between the bank and its lane FIFO monitor.
`timescale 1ns/1ps
interface ieb_lane_if #(
   parameter int unsigned LANES = 8 // Number of lanes carried.
);
   logic [LANES-1:0] fifo_full; // Live full flags, one per lane.
   logic [LANES-1:0] fifo_empty; // Live empty flags, one per lane.
   logic link_en; // Link enabled while high.
   logic [LANES-1:0] full_seen; // Sticky full flags.
   logic [LANES-1:0] empty_seen; // Sticky empty flags.
   logic fault; // Lane FIFO fault held.

   // The monitor watches the flags and reports the fault.
   modport mon (
      input fifo_full, fifo_empty, link_en,
      output full_seen, empty_seen, fault
   );

   // The bank feeds the flags and reads the results.
   modport hub (
      output fifo_full, fifo_empty, link_en,
      input full_seen, empty_seen, fault
   );
endinterface

// File: design/ieb_lane_mon.sv
// Lane FIFO monitor that catches and holds full or empty conditions.
`timescale 1ns/1ps
module ieb_lane_mon
   import ieb_pkg::*;
#(
   parameter int unsigned LANES = IEB_LANES // Number of lanes watched.
) (
   input wire logic ref_clk, // Register clock.
   input wire logic sys_rst, // Synchronous reset, active high.
   ieb_lane_if.mon lane // Flags in, held results out.
);

   ieb_mon_state_t state_r; // Current monitor state.
   ieb_mon_state_t state_nxt; // Next monitor state.
   logic any_hit; // Some lane is full or empty now.

   assign any_hit = |(lane.fifo_full | lane.fifo_empty);

   // Per-lane sticky flags; a disabled link wipes them so re-enable starts clean.
   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         // [RQ3] clear on disable
         always_ff @(posedge ref_clk) begin
            if (sys_rst || !lane.link_en) begin
               lane.full_seen[gi] <= 1'b0;
               lane.empty_seen[gi] <= 1'b0;
            end else begin
               if (lane.fifo_full[gi]) begin
                  lane.full_seen[gi] <= 1'b1;
               end
               if (lane.fifo_empty[gi]) begin
                  lane.empty_seen[gi] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // Next state: a hit while running latches the fault until the link drops.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         IEB_MON_OFF: begin
            if (lane.link_en) begin
               state_nxt = IEB_MON_RUN;
            end
         end
         // [RQ2] full or empty
         IEB_MON_RUN: begin
            if (!lane.link_en) begin
               state_nxt = IEB_MON_OFF;
            end else if (any_hit) begin
               state_nxt = IEB_MON_FAULT;
            end
         end
         // [RQ3] hold until disable
         IEB_MON_FAULT: begin
            if (!lane.link_en) begin
               state_nxt = IEB_MON_OFF;
            end
         end
         default: begin
            state_nxt = IEB_MON_OFF;
         end
      endcase
   end

   // State register.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= IEB_MON_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign lane.fault = (state_r == IEB_MON_FAULT);

   default clocking mon_cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   fault_catch_a: assert property ((state_r == IEB_MON_RUN) && lane.link_en && any_hit // [RQ2]
      |=> lane.fault) else $error("Lane FIFO hit did not raise the fault.");
   fault_hold_a: assert property (lane.fault && lane.link_en |=> lane.fault) // [RQ3]
      else $error("Lane FIFO fault dropped while the link stayed enabled.");
   fault_clear_a: assert property (!lane.link_en |=> !lane.fault && !(|lane.full_seen)) // [RQ3]
      else $error("Lane FIFO fault survived a link disable.");

endmodule

// File: design/ieb_pkg.sv
// Constants, register map and state codes of the interrupt enable bank.
// Function
// [RQ1] Lane FIFO fault reported only when enabled.
// [RQ2] Any lane FIFO full or empty raises fault.
// [RQ3] Fault holds until link off then on.
// [RQ4] Lane full at 0x30C, empty at 0x30D.
// [RQ5] 0x020 bits 3,2 gate pair B checks.
// [RQ6] 0x020 bits 1,0 gate pair A checks.
// [RQ7] 0x021 bit 5 blanking, bit 7 amplifier.
// [RQ8] 0x021 bit 4 gates oscillator clear trip.
// [RQ9] Enables reset zero, masking keeps status.
package ieb_pkg;

   // Number of deserializer lanes watched by the FIFO monitor.
   localparam int unsigned IEB_LANES = 8;

   // Register offsets on the plain register port.
   localparam logic [11:0] IEB_ADDR_LANE_EN = 12'h01f;
   localparam logic [11:0] IEB_ADDR_PAT_EN = 12'h020;
   localparam logic [11:0] IEB_ADDR_LINK_EN = 12'h021;
   localparam logic [11:0] IEB_ADDR_EVT_STAT = 12'h040;
   localparam logic [11:0] IEB_ADDR_FIFO_FULL = 12'h30c;
   localparam logic [11:0] IEB_ADDR_FIFO_EMPTY = 12'h30d;

   // Field positions inside the enable registers.
   localparam int unsigned IEB_LANE_FAULT_BIT = 1;
   localparam int unsigned IEB_PB_IMAG_BIT = 3;
   localparam int unsigned IEB_PB_REAL_BIT = 2;
   localparam int unsigned IEB_PA_IMAG_BIT = 1;
   localparam int unsigned IEB_PA_REAL_BIT = 0;
   localparam int unsigned IEB_AMP_BIT = 7;
   localparam int unsigned IEB_BLANK_BIT = 5;
   localparam int unsigned IEB_OSC_BIT = 4;

   // Bits that software may write; all others read as zero.
   localparam logic [7:0] IEB_LANE_EN_WMASK = 8'h03;
   localparam logic [7:0] IEB_PAT_EN_WMASK = 8'h0f;
   localparam logic [7:0] IEB_LINK_EN_WMASK = 8'hf0;

   // Reset values of every register.
   localparam logic [7:0] IEB_EN_RESET = 8'h00;
   localparam logic [7:0] IEB_STAT_RESET = 8'h00;

   // Positions of the events in the sticky status word.
   localparam int unsigned IEB_EVT_LANE = 0;
   localparam int unsigned IEB_EVT_PA_REAL = 1;
   localparam int unsigned IEB_EVT_PA_IMAG = 2;
   localparam int unsigned IEB_EVT_PB_REAL = 3;
   localparam int unsigned IEB_EVT_PB_IMAG = 4;
   localparam int unsigned IEB_EVT_OSC = 5;
   localparam int unsigned IEB_EVT_BLANK = 6;
   localparam int unsigned IEB_EVT_AMP = 7;

   // States of the lane FIFO monitor.
   typedef enum logic [2:0] {
      IEB_MON_OFF = 3'b001,
      IEB_MON_RUN = 3'b010,
      IEB_MON_FAULT = 3'b100
   } ieb_mon_state_t;

endpackage

// File: design/ieb_top.sv
// Interrupt enable bank with sticky event status, masking and lane FIFO monitor.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module ieb_top
   import ieb_pkg::*;
#(
   parameter int unsigned LANES = IEB_LANES // Number of lanes watched.
) (
   input wire logic ref_clk, // Register clock, 20 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic [11:0] reg_addr, // Register address.
   input wire logic [7:0] reg_wdata, // Register write data.
   input wire logic reg_wr, // Write strobe, one cycle.
   input wire logic reg_rd, // Read strobe, one cycle.
   output logic [7:0] reg_rdata, // Read data, valid the cycle after a read.
   input wire logic [LANES-1:0] lane_fifo_full, // Lane FIFO full flags.
   input wire logic [LANES-1:0] lane_fifo_empty, // Lane FIFO empty flags.
   input wire logic link_a_enable, // First link enabled while high.
   input wire logic pair_a_real_alarm, // Pattern error, pair A real path.
   input wire logic pair_a_imag_alarm, // Pattern error, pair A imaginary path.
   input wire logic pair_b_real_alarm, // Pattern error, pair B real path.
   input wire logic pair_b_imag_alarm, // Pattern error, pair B imaginary path.
   input wire logic link_a_amp_fault, // First link amplifier error pulse.
   input wire logic link_a_blank_done, // First link blanking done pulse.
   input wire logic link_a_osc_clear_trip, // First link oscillator clear trip.
   output logic lane_fifo_fault, // Lane FIFO fault held, level.
   output logic irq // Interrupt request, high while enabled status set.
);

   logic [7:0] lane_en_r; // Lane FIFO fault enable register.
   logic [7:0] pat_en_r; // Pattern checker enable register.
   logic [7:0] link_en_r; // First link event enable register.
   logic [7:0] evt_stat_r; // Sticky event status.
   logic [7:0] evt_raw; // Events seen this cycle.
   logic [7:0] evt_mask; // Enable bits gathered in status layout.
   logic [7:0] evt_clr; // Bits cleared by a status read.
   logic [7:0] rdata_nxt; // Read data for the next cycle.
   logic wr_lane; // Write to the lane enable register.
   logic wr_pat; // Write to the pattern enable register.
   logic wr_link; // Write to the link enable register.
   logic rd_stat; // Read of the event status register.

   ieb_lane_if #(.LANES(LANES)) lane_bus (); // Link to the FIFO monitor.

   // Feed the monitor; all sources share the register clock.
   assign lane_bus.fifo_full = lane_fifo_full;
   assign lane_bus.fifo_empty = lane_fifo_empty;
   assign lane_bus.link_en = link_a_enable;

   // The monitor holds the lane FIFO fault until the link is cycled.
   ieb_lane_mon #(.LANES(LANES)) u_mon (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .lane(lane_bus.mon)
   );

   assign lane_fifo_fault = lane_bus.fault;

   // Address decode; writes and reads never overlap, so no arbitration.
   assign wr_lane = reg_wr && (reg_addr == IEB_ADDR_LANE_EN);
   assign wr_pat = reg_wr && (reg_addr == IEB_ADDR_PAT_EN);
   assign wr_link = reg_wr && (reg_addr == IEB_ADDR_LINK_EN);
   assign rd_stat = reg_rd && (reg_addr == IEB_ADDR_EVT_STAT);

   // Lane fault enable; the reserved low bit keeps what software wrote.
   // [RQ9] zero at reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         lane_en_r <= IEB_EN_RESET;
      end else if (wr_lane) begin
         lane_en_r <= reg_wdata & IEB_LANE_EN_WMASK;
      end
   end

   // Pattern checker enables; the upper nibble is read-only zero.
   // [RQ5] reserved nibble dropped
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pat_en_r <= IEB_EN_RESET;
      end else if (wr_pat) begin
         pat_en_r <= reg_wdata & IEB_PAT_EN_WMASK;
      end
   end

   // First link enables; reserved bit 6 stays writable as it is R/W.
   // [RQ7] link enables stored
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         link_en_r <= IEB_EN_RESET;
      end else if (wr_link) begin
         link_en_r <= reg_wdata & IEB_LINK_EN_WMASK;
      end
   end

   // Gather raw events. The lane fault is a level, so it re-sets its status
   // bit after a read until the link is cycled; that is intended.
   always_comb begin
      evt_raw = 8'h00;
      evt_raw[IEB_EVT_LANE] = lane_bus.fault;
      evt_raw[IEB_EVT_PA_REAL] = pair_a_real_alarm;
      evt_raw[IEB_EVT_PA_IMAG] = pair_a_imag_alarm;
      evt_raw[IEB_EVT_PB_REAL] = pair_b_real_alarm;
      evt_raw[IEB_EVT_PB_IMAG] = pair_b_imag_alarm;
      evt_raw[IEB_EVT_OSC] = link_a_osc_clear_trip;
      evt_raw[IEB_EVT_BLANK] = link_a_blank_done;
      evt_raw[IEB_EVT_AMP] = link_a_amp_fault;
   end

   // Gather the scattered enable bits into the status layout.
   always_comb begin
      evt_mask = 8'h00;
      // [RQ1] lane fault gate
      evt_mask[IEB_EVT_LANE] = lane_en_r[IEB_LANE_FAULT_BIT];
      // [RQ6] pair A gates
      evt_mask[IEB_EVT_PA_REAL] = pat_en_r[IEB_PA_REAL_BIT];
      evt_mask[IEB_EVT_PA_IMAG] = pat_en_r[IEB_PA_IMAG_BIT];
      // [RQ5] pair B gates
      evt_mask[IEB_EVT_PB_REAL] = pat_en_r[IEB_PB_REAL_BIT];
      evt_mask[IEB_EVT_PB_IMAG] = pat_en_r[IEB_PB_IMAG_BIT];
      // [RQ8] oscillator clear gate
      evt_mask[IEB_EVT_OSC] = link_en_r[IEB_OSC_BIT];
      // [RQ7] blanking, amplifier gates
      evt_mask[IEB_EVT_BLANK] = link_en_r[IEB_BLANK_BIT];
      evt_mask[IEB_EVT_AMP] = link_en_r[IEB_AMP_BIT];
   end

   // A status read clears every bit it returned.
   assign evt_clr = rd_stat ? evt_stat_r : 8'h00;

   // Sticky status records events whatever the enables say, so a masked
   // event is still visible and fires as soon as it is enabled.
   // [RQ9] status kept when masked
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         evt_stat_r <= IEB_STAT_RESET;
      end else begin
         evt_stat_r <= (evt_stat_r & ~evt_clr) | evt_raw;
      end
   end

   // Only enabled status bits reach the request line.
   // [RQ9] enable gates request
   assign irq = |(evt_stat_r & evt_mask);

   // Read multiplexer; unmapped addresses answer zero.
   always_comb begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         IEB_ADDR_LANE_EN: begin
            rdata_nxt = lane_en_r;
         end
         IEB_ADDR_PAT_EN: begin
            rdata_nxt = pat_en_r;
         end
         IEB_ADDR_LINK_EN: begin
            rdata_nxt = link_en_r;
         end
         IEB_ADDR_EVT_STAT: begin
            rdata_nxt = evt_stat_r;
         end
         // [RQ4] full flags
         IEB_ADDR_FIFO_FULL: begin
            rdata_nxt = 8'(lane_bus.full_seen);
         end
         // [RQ4] empty flags
         IEB_ADDR_FIFO_EMPTY: begin
            rdata_nxt = 8'(lane_bus.empty_seen);
         end
         default: begin
            rdata_nxt = 8'h00;
         end
      endcase
   end

   // Read data stand for exactly the cycle after the strobe.
   // Zero elsewhere, so a late sample can never pass off old data as an answer.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   default clocking top_cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // A write to the pattern register followed directly by its readback.
   sequence pat_write_s;
      reg_wr && (reg_addr == IEB_ADDR_PAT_EN);
   endsequence

   sequence pat_read_s;
      reg_rd && (reg_addr == IEB_ADDR_PAT_EN);
   endsequence

   sequence link_write_s;
      reg_wr && (reg_addr == IEB_ADDR_LINK_EN);
   endsequence

   sequence link_read_s;
      reg_rd && (reg_addr == IEB_ADDR_LINK_EN);
   endsequence

   lane_gate_on_a: assert property ($rose(lane_bus.fault) && lane_en_r[IEB_LANE_FAULT_BIT] // [RQ1]
      && !wr_lane |=> irq) else $error("Enabled lane FIFO fault gave no interrupt.");
   lane_gate_off_a: assert property (!lane_en_r[IEB_LANE_FAULT_BIT] // [RQ1]
      && ((evt_stat_r & evt_mask & 8'hfe) == 8'h00) |-> !irq)
      else $error("Disabled lane FIFO fault raised the interrupt.");
   pat_readback_a: assert property (pat_write_s ##1 pat_read_s // [RQ5]
      |=> reg_rdata == ($past(reg_wdata, 2) & IEB_PAT_EN_WMASK))
      else $error("Pattern enable readback wrong.");
   pair_a_real_a: assert property (pair_a_real_alarm && pat_en_r[IEB_PA_REAL_BIT] // [RQ6]
      && !wr_pat |=> irq ##1 (irq || $past(rd_stat)))
      else $error("Enabled pair A real alarm gave no interrupt.");
   link_readback_a: assert property (link_write_s ##1 link_read_s // [RQ7]
      |=> reg_rdata == ($past(reg_wdata, 2) & IEB_LINK_EN_WMASK))
      else $error("Link enable readback wrong.");
   blank_done_a: assert property (link_a_blank_done && link_en_r[IEB_BLANK_BIT] // [RQ7]
      && !wr_link |=> irq && evt_stat_r[IEB_EVT_BLANK])
      else $error("Enabled blanking done gave no interrupt.");
   osc_trip_a: assert property (link_a_osc_clear_trip && link_en_r[IEB_OSC_BIT] // [RQ8]
      && !wr_link |=> irq) else $error("Enabled oscillator clear trip gave no interrupt.");
   enable_reset_a: assert property ($fell(sys_rst) |-> (evt_mask == 8'h00) && !irq) // [RQ9]
      else $error("Enables not zero after reset.");
   mask_keeps_a: assert property (!rd_stat |=> (evt_stat_r & $past(evt_stat_r)) // [RQ9]
      == $past(evt_stat_r)) else $error("Status bit lost without a read.");
   full_read_a: assert property (reg_rd && (reg_addr == IEB_ADDR_FIFO_FULL) // [RQ4]
      |=> reg_rdata == 8'($past(lane_bus.full_seen)))
      else $error("Lane full flags read wrong.");
   empty_read_a: assert property (reg_rd && (reg_addr == IEB_ADDR_FIFO_EMPTY) // [RQ4]
      |=> reg_rdata == 8'($past(lane_bus.empty_seen)))
      else $error("Lane empty flags read wrong.");

   // A status read strobe, the step that returns the sticky word and clears it.
   sequence stat_read_s;
      reg_rd && (reg_addr == IEB_ADDR_EVT_STAT);
   endsequence

   // The held fault keeps setting its status bit, even across a status read.
   lane_status_a: assert property (lane_bus.fault // [RQ1]
      |=> evt_stat_r[IEB_EVT_LANE])
      else $error("Lane FIFO fault did not set its status bit.");

   // A lane enable write keeps only the writable bits.
   lane_write_a: assert property (wr_lane // [RQ1]
      |=> lane_en_r == ($past(reg_wdata) & IEB_LANE_EN_WMASK))
      else $error("Lane enable register took a wrong value.");

   // A pattern enable write keeps only the low nibble.
   pat_write_a: assert property (pat_write_s // [RQ5]
      |=> pat_en_r == ($past(reg_wdata) & IEB_PAT_EN_WMASK))
      else $error("Pattern enable register took a wrong value.");

   // The reserved upper nibble of the pattern enables never holds a one.
   pat_reserved_a: assert property ( // [RQ5]
      pat_en_r[7:4] == 4'h0)
      else $error("Reserved pattern enable bits set.");

   // An enabled pair A imaginary alarm reaches the request line next cycle.
   pair_a_imag_a: assert property (pair_a_imag_alarm && pat_en_r[IEB_PA_IMAG_BIT] // [RQ6]
      && !wr_pat |=> irq && evt_stat_r[IEB_EVT_PA_IMAG])
      else $error("Enabled pair A imaginary alarm gave no interrupt.");

   // An enabled pair B real alarm reaches the request line next cycle.
   pair_b_real_a: assert property (pair_b_real_alarm && pat_en_r[IEB_PB_REAL_BIT] // [RQ5]
      && !wr_pat |=> irq && evt_stat_r[IEB_EVT_PB_REAL])
      else $error("Enabled pair B real alarm gave no interrupt.");

   // An enabled pair B imaginary alarm reaches the request line next cycle.
   pair_b_imag_a: assert property (pair_b_imag_alarm && pat_en_r[IEB_PB_IMAG_BIT] // [RQ5]
      && !wr_pat |=> irq && evt_stat_r[IEB_EVT_PB_IMAG])
      else $error("Enabled pair B imaginary alarm gave no interrupt.");

   // A link enable write keeps only the upper nibble.
   link_write_a: assert property (link_write_s // [RQ7]
      |=> link_en_r == ($past(reg_wdata) & IEB_LINK_EN_WMASK))
      else $error("Link enable register took a wrong value.");

   // An enabled amplifier error reaches the request line next cycle.
   amp_fault_a: assert property (link_a_amp_fault && link_en_r[IEB_AMP_BIT] // [RQ7]
      && !wr_link |=> irq && evt_stat_r[IEB_EVT_AMP])
      else $error("Enabled amplifier error gave no interrupt.");

   // A masked oscillator clear trip is still recorded for later.
   masked_status_a: assert property (link_a_osc_clear_trip && !link_en_r[IEB_OSC_BIT] // [RQ9]
      |=> evt_stat_r[IEB_EVT_OSC])
      else $error("Masked event lost its status bit.");

   // A status read answers with the word that stood at the strobe.
   stat_read_a: assert property (stat_read_s // [RQ9]
      |=> reg_rdata == $past(evt_stat_r))
      else $error("Event status read wrong.");

   // A status read with no new event leaves the word empty.
   read_clear_a: assert property (rd_stat && (evt_raw == 8'h00) // [RQ9]
      |=> evt_stat_r == 8'h00)
      else $error("Event status not cleared by its read.");

endmodule

// File: tb/tb_top.sv
// Self-checking testbench of the interrupt enable bank.
`timescale 1ns/1ps
module tb_top
   import ieb_pkg::*;
;
   // Register rows: address, value written, value expected back.
   typedef struct {logic [11:0] addr; logic [7:0] wdata; logic [7:0] exp;} ieb_reg_row_t;
   // Event rows: status position, enable register and the enable value.
   typedef struct {int idx; logic [11:0] en_addr; logic [7:0] en_data;} ieb_evt_row_t;
   logic ref_clk = 1'b0; // Register clock, 50 ns period.
   logic sys_rst = 1'b1; // Synchronous reset, held at start.
   logic [11:0] reg_addr = 12'h000; // Register address.
   logic [7:0] reg_wdata = 8'h00; // Write data.
   logic reg_wr = 1'b0; // Write strobe.
   logic reg_rd = 1'b0; // Read strobe.
   logic [7:0] reg_rdata; // Read data from the bank.
   logic [IEB_LANES-1:0] lane_full = 8'h00; // Lane full flags driven in.
   logic [IEB_LANES-1:0] lane_empty = 8'h00; // Lane empty flags driven in.
   logic link_en = 1'b0; // First link enable.
   logic [7:0] evt = 8'h00; // Event inputs, laid out as the status word.
   logic lane_fifo_fault; // Held lane fault seen.
   logic irq; // Interrupt request seen.
   logic [7:0] d; // Last read value.
   int err_count = 0; // Mismatches found.
   int total_checks = 0; // Comparisons made.
   // Addresses whose reset value is zero.
   logic [11:0] rst_addrs [6] = '{12'h01f, 12'h020, 12'h021, 12'h040, 12'h30c, 12'h30d};
   // Write masks of the three enable registers, read-only 0x30c and unmapped 0x100 included.
   ieb_reg_row_t reg_rows [7] = '{'{12'h01f, 8'hff, 8'h03}, '{12'h020, 8'hff, 8'h0f},
      '{12'h021, 8'hff, 8'hf0}, '{12'h020, 8'h5a, 8'h0a}, '{12'h021, 8'ha5, 8'ha0},
      '{12'h30c, 8'hff, 8'h00}, '{12'h100, 8'hff, 8'h00}};
   // Each event but the lane fault beside the enable bit that gates it.
   ieb_evt_row_t evt_rows [7] = '{'{1, 12'h020, 8'h01}, '{2, 12'h020, 8'h02},
      '{3, 12'h020, 8'h04}, '{4, 12'h020, 8'h08}, '{5, 12'h021, 8'h10},
      '{6, 12'h021, 8'h20}, '{7, 12'h021, 8'h80}};

   // The clock toggles every half period.
   always #25 ref_clk = ~ref_clk;

   // Device under test, every input driven by the bench.
   ieb_top i_dut (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .lane_fifo_full(lane_full),
      .lane_fifo_empty(lane_empty),
      .link_a_enable(link_en),
      .pair_a_real_alarm(evt[1]),
      .pair_a_imag_alarm(evt[2]),
      .pair_b_real_alarm(evt[3]),
      .pair_b_imag_alarm(evt[4]),
      .link_a_amp_fault(evt[7]),
      .link_a_blank_done(evt[6]),
      .link_a_osc_clear_trip(evt[5]),
      .lane_fifo_fault(lane_fifo_fault),
      .irq(irq)
   );

   // Compares an 8-bit result.
   task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Compares a one-bit result.
   task automatic chk_bit(input string name, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask

   // One write cycle; entered and left at a rising edge.
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // One read cycle; the data are taken mid-cycle after the strobe, where they stand.
   task automatic rd_reg(input logic [11:0] a, output logic [7:0] v);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      v = reg_rdata;
      @(posedge ref_clk);
   endtask

   // Raises the chosen events for one cycle.
   task automatic pulse(input logic [7:0] m);
      evt <= m;
      @(posedge ref_clk);
      evt <= 8'h00;
   endtask

   // Looks at both output flags mid-cycle, then returns to the edge.
   task automatic flags(input logic ei, input logic ef);
      @(negedge ref_clk);
      chk_bit("irq", ei, irq);
      chk_bit("lane_fifo_fault", ef, lane_fifo_fault);
      @(posedge ref_clk);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watchdog, far beyond the roughly 175 cycles the tests need.
   initial begin
      repeat (3000) @(posedge ref_clk);
      err_count++;
      complete_run();
   end

   // Main sequence.
   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      flags(1'b0, 1'b0);
      foreach (rst_addrs[i]) begin
         rd_reg(rst_addrs[i], d);
         chk_reg("reset value", 8'h00, d);
      end
      $display("test reset done");
      foreach (reg_rows[i]) begin
         wr_reg(reg_rows[i].addr, reg_rows[i].wdata);
         rd_reg(reg_rows[i].addr, d);
         chk_reg("readback", reg_rows[i].exp, d);
      end
      // An edge passes between writes, so the strobe is never assigned twice at once.
      wr_reg(12'h01f, 8'h00);
      @(posedge ref_clk);
      wr_reg(12'h020, 8'h00);
      @(posedge ref_clk);
      wr_reg(12'h021, 8'h00);
      $display("test registers done");
      // Each event first masked, then enabled; status must be kept either way.
      foreach (evt_rows[i]) begin
         for (int p = 0; p < 2; p++) begin
            wr_reg(evt_rows[i].en_addr, (p == 1) ? evt_rows[i].en_data : 8'h00);
            pulse(8'h01 << evt_rows[i].idx);
            flags(p[0], 1'b0);
            rd_reg(12'h040, d);
            chk_reg("event status", 8'h01 << evt_rows[i].idx, d);
            flags(1'b0, 1'b0);
         end
      end
      $display("test events done");
      wr_reg(12'h021, 8'h20);
      pulse(8'h40);
      flags(1'b1, 1'b0);
      wr_reg(12'h021, 8'h00);
      flags(1'b0, 1'b0);
      wr_reg(12'h021, 8'h20);
      flags(1'b1, 1'b0);
      // A status read that meets a new event must not lose it.
      evt <= 8'h40;
      rd_reg(12'h040, d);
      evt <= 8'h00;
      chk_reg("status on coincident read", 8'h40, d);
      rd_reg(12'h040, d);
      chk_reg("status kept", 8'h40, d);
      wr_reg(12'h021, 8'h00);
      $display("test masking done");
      link_en <= 1'b1;
      repeat (3) @(posedge ref_clk);
      lane_full <= 8'h08;
      @(posedge ref_clk);
      lane_full <= 8'h00;
      flags(1'b0, 1'b1);
      wr_reg(12'h01f, 8'h02);
      flags(1'b1, 1'b1);
      rd_reg(12'h30c, d);
      chk_reg("lane full flags", 8'h08, d);
      lane_empty <= 8'h20;
      @(posedge ref_clk);
      lane_empty <= 8'h00;
      rd_reg(12'h30d, d);
      chk_reg("lane empty flags", 8'h20, d);
      rd_reg(12'h040, d);
      rd_reg(12'h040, d);
      chk_reg("fault status held", 8'h01, d);
      link_en <= 1'b0;
      repeat (2) @(posedge ref_clk);
      flags(1'b1, 1'b0);
      rd_reg(12'h040, d);
      rd_reg(12'h040, d);
      chk_reg("fault status cleared", 8'h00, d);
      rd_reg(12'h30c, d);
      chk_reg("lane full cleared", 8'h00, d);
      link_en <= 1'b1;
      repeat (3) @(posedge ref_clk);
      flags(1'b0, 1'b0);
      // A fresh fault meets an enable already set, then the enable is taken away.
      lane_empty <= 8'h01;
      @(posedge ref_clk);
      lane_empty <= 8'h00;
      flags(1'b0, 1'b1);
      flags(1'b1, 1'b1);
      wr_reg(12'h01f, 8'h00);
      flags(1'b0, 1'b1);
      $display("test lane fault done");
      complete_run();
   end
endmodule
